// ---- logic/distortion_pkg.sv ----
// constants shared by the harmonic distortion monitor
package distortion_pkg;
  // clock and program cycle timing
  localparam int CLK_PERIOD_NS     = 100;
  localparam int PROGRAM_CYCLE_NS  = 5_000_000;
  localparam int CYCLE_CLKS        = (PROGRAM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // spectrum layout: index 0 dc, 1 fundamental, 2..31 harmonics
  localparam int          COMPONENTS   = 32;
  localparam logic [4:0]  ORDER_DC     = 5'h00;
  localparam logic [4:0]  ORDER_FUND   = 5'h01;
  localparam logic [4:0]  ORDER_LAST   = 5'h1F;

  // threshold in hundredths of a percent
  localparam int          THR_W        = 14;
  localparam logic [13:0] THR_MAX      = 14'h2710;
  localparam logic [13:0] THR_RESET    = 14'h03E8;

  // comparison scales, power ratio and amplitude ratio
  localparam logic [63:0] PU_PWR_SCALE = 64'h0000_0000_0000_2710;
  localparam logic [63:0] PU_AMP_SCALE = 64'h0000_0000_05F5_E100;
  localparam logic [63:0] DO_PWR_SCALE = 64'h0000_0000_000F_4240;
  localparam logic [63:0] DO_AMP_SCALE = 64'h0000_00E8_D4A5_1000;
  localparam logic [63:0] DO_PWR_RATIO = 64'h0000_0000_0000_0061;
  localparam logic [63:0] DO_AMP_RATIO = 64'h0000_0000_0000_24C1;

  // alarm delay in 5 ms steps
  localparam int          DLY_W        = 19;
  localparam logic [18:0] DLY_MAX      = 19'h57E40;
  localparam logic [18:0] DLY_RESET    = 19'h007D0;

  // register byte offsets
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_THR_PH   = 8'h04;
  localparam logic [7:0]  OFS_THR_R1   = 8'h08;
  localparam logic [7:0]  OFS_THR_R2   = 8'h0C;
  localparam logic [7:0]  OFS_DLY_PH   = 8'h10;
  localparam logic [7:0]  OFS_DLY_R1   = 8'h14;
  localparam logic [7:0]  OFS_DLY_R2   = 8'h18;
  localparam logic [7:0]  OFS_STATUS   = 8'h1C;
  localparam logic [7:0]  OFS_CNT_ST   = 8'h20;
  localparam logic [7:0]  OFS_CNT_AL   = 8'h24;
  localparam logic [7:0]  OFS_CNT_BL   = 8'h28;

  // control fields
  localparam int          CTRL_METHOD  = 0;
  localparam int          CTRL_EN_LSB  = 1;
  localparam logic [3:0]  CTRL_RESET   = 4'hE;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_ALARM, COND_BLOCKED} condition_t;
endpackage

// ---- logic/distortion_channel.sv ----
// one current channel: accumulates a spectrum and keeps its pick-up state
module distortion_channel #(
  parameter int MAG_W = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // spectrum components
  input  wire logic             comp_valid,
  input  wire logic [4:0]       comp_order,
  input  wire logic [MAG_W-1:0] comp_mag,
  // settings
  input  wire logic             power_mode,
  input  wire logic [13:0]      threshold,
  // result
  output logic                  picked,
  output logic                  done
);
  localparam int SUM_W = 2 * MAG_W + 5;

  logic [SUM_W-1:0]   sum;
  logic [2*MAG_W-1:0] fund;
  logic [SUM_W-1:0]   next_sum;
  logic [2*MAG_W-1:0] next_fund;
  logic               next_picked;
  logic               next_done;

  // pick-up compares above the setting, drop-out below 97 % of it
  function automatic logic crosses(input logic [SUM_W-1:0] s, input logic [2*MAG_W-1:0] f,
                                   input logic [13:0] t, input logic pm, input logic drop);
    logic [95:0] tt;
    logic [95:0] lhs;
    logic [95:0] rhs;
    tt  = pm ? 96'(t) : 96'(t) * 96'(t);
    lhs = 96'(s) * (pm ? 96'(drop ? distortion_pkg::DO_PWR_SCALE : distortion_pkg::PU_PWR_SCALE)
                       : 96'(drop ? distortion_pkg::DO_AMP_SCALE : distortion_pkg::PU_AMP_SCALE));
    rhs = tt * 96'(f);
    if (drop) begin
      rhs = rhs * 96'(pm ? distortion_pkg::DO_PWR_RATIO : distortion_pkg::DO_AMP_RATIO);
    end
    crosses = drop ? (lhs < rhs) : (lhs > rhs);
  endfunction

  always_comb begin
    logic [2*MAG_W-1:0] sq;
    logic [SUM_W-1:0]   acc;
    sq          = (2*MAG_W)'(comp_mag) * (2*MAG_W)'(comp_mag);
    acc         = sum + SUM_W'(sq);
    next_sum    = sum;
    next_fund   = fund;
    next_picked = picked;
    next_done   = 1'b0;
    if (comp_valid) begin
      if (comp_order == distortion_pkg::ORDER_DC) begin
        next_sum = '0;
      end else if (comp_order == distortion_pkg::ORDER_FUND) begin
        next_fund = sq;
      end else begin
        next_sum = acc;
        if (comp_order == distortion_pkg::ORDER_LAST) begin
          next_done = 1'b1;
          if (!picked && crosses(acc, fund, threshold, power_mode, 1'b0)) begin
            next_picked = 1'b1;
          end else if (picked && crosses(acc, fund, threshold, power_mode, 1'b1)) begin
            next_picked = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum    <= '0;
      fund   <= '0;
      picked <= 1'b0;
      done   <= 1'b0;
    end else begin
      sum    <= next_sum;
      fund   <= next_fund;
      picked <= next_picked;
      done   <= next_done;
    end
  end

  a_pick_at_end: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(picked) |-> $past(comp_valid) && $past(comp_order) == 5'h1F)
    else $error("pick-up changed outside end of spectrum");
endmodule // distortion_channel

// ---- logic/distortion_monitor.sv ----
// harmonic distortion monitor top with its register slave
module distortion_monitor #(
  parameter int MAG_W       = 16,
  parameter int CYCLE_CLKS  = distortion_pkg::CYCLE_CLKS,
  parameter int CNT_W       = 16
) (
  // clock and reset
  input  wire logic             SYS_CLK,
  input  wire logic             NRST,
  // spectrum source, channels 0..2 phases, 3 and 4 residual
  input  wire logic             SPEC_VALID,
  input  wire logic [2:0]       SPEC_CHANNEL,
  input  wire logic [4:0]       SPEC_ORDER,
  input  wire logic [MAG_W-1:0] SPEC_MAGNITUDE,
  // blocking matrix
  input  wire logic             BLOCK,
  // element outputs: bit 0 phase, 1 residual one, 2 residual two
  output logic [2:0]            START,
  output logic [2:0]            ALARM,
  output logic [2:0]            BLOCKED,
  output logic [1:0]            MONITOR_CONDITION,
  // events: bits 2:0 start, 5:3 alarm, 6 blocked
  output logic [6:0]            EVENT_ON,
  output logic [6:0]            EVENT_OFF,
  // axi4-lite write
  input  wire logic [7:0]       AWADDR,
  input  wire logic             AWVALID,
  output logic                  AWREADY,
  input  wire logic [31:0]      WDATA,
  input  wire logic [3:0]       WSTRB,
  input  wire logic             WVALID,
  output logic                  WREADY,
  output logic [1:0]            BRESP,
  output logic                  BVALID,
  input  wire logic             BREADY,
  // axi4-lite read
  input  wire logic [7:0]       ARADDR,
  input  wire logic             ARVALID,
  output logic                  ARREADY,
  output logic [31:0]           RDATA,
  output logic [1:0]            RRESP,
  output logic                  RVALID,
  input  wire logic             RREADY
);
  localparam int DW = distortion_pkg::DLY_W;

  if (CYCLE_CLKS < 2 || MAG_W < 4 || MAG_W > 24 || CNT_W < 2 || CNT_W > 32) begin : g_check
    $error("distortion_monitor: unsupported parameter value");
  end

  // reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // state
  logic [31:0]       cyc;
  logic              tick;
  logic              method;
  logic [2:0]        enable;
  logic [13:0]       thr [3];
  logic [DW-1:0]     dly [3];
  logic [DW-1:0]     tmr [3];
  logic [CNT_W-1:0]  cnt [3];
  logic              aw_have;
  logic              w_have;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic [4:0]        picks;
  logic [2:0]        pick;

  logic [31:0]       next_cyc;
  logic              next_tick;
  logic              next_method;
  logic [2:0]        next_enable;
  logic [13:0]       next_thr [3];
  logic [DW-1:0]     next_dly [3];
  logic [DW-1:0]     next_tmr [3];
  logic [CNT_W-1:0]  next_cnt [3];
  logic [2:0]        next_start;
  logic [2:0]        next_alarm;
  logic [2:0]        next_blocked;
  logic [1:0]        next_cond;
  logic [6:0]        next_on;
  logic [6:0]        next_off;
  logic              next_aw_have;
  logic              next_w_have;
  logic [7:0]        next_aw_addr;
  logic [31:0]       next_w_data;
  logic [3:0]        next_w_strb;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;

  // channel pick-up, each phase against the shared threshold
  for (genvar c = 0; c < 5; c++) begin : g_chan
    distortion_channel #(.MAG_W(MAG_W)) u_chan (
      .clk        (SYS_CLK),
      .rst_n      (rst_n),
      .comp_valid (SPEC_VALID && SPEC_CHANNEL == 3'(c)),
      .comp_order (SPEC_ORDER),
      .comp_mag   (SPEC_MAGNITUDE),
      .power_mode (method),
      .threshold  (thr[c < 3 ? 0 : c - 2]),
      .picked     (picks[c]),
      .done       ()
    );
  end

  assign pick[0] = enable[0] && |picks[2:0];
  assign pick[1] = enable[1] && picks[3];
  assign pick[2] = enable[2] && picks[4];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) old[8*b +: 8] = d[8*b +: 8];
    end
    merge = old;
  endfunction

  function automatic logic [1:0] ones(input logic [2:0] v);
    ones = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
  endfunction

  always_comb begin
    logic [31:0] wv;
    logic        wr;
    wv           = 32'h0;
    wr           = aw_have && w_have && !BVALID;
    next_cyc     = (cyc >= 32'(CYCLE_CLKS - 1)) ? 32'h0 : cyc + 32'h1;
    next_tick    = (cyc == 32'(CYCLE_CLKS - 1));
    next_method  = method;
    next_enable  = enable;
    next_thr     = thr;
    next_dly     = dly;
    next_tmr     = tmr;
    next_cnt     = cnt;
    next_start   = START;
    next_alarm   = ALARM;
    next_blocked = BLOCKED;
    next_on      = 7'h00;
    next_off     = 7'h00;
    // element sequencing once per program cycle, blocking sampled here
    if (tick) begin
      for (int i = 0; i < 3; i++) begin
        if (!pick[i]) begin
          next_start[i]   = 1'b0;
          next_blocked[i] = 1'b0;
          next_alarm[i]   = 1'b0;
          next_tmr[i]     = '0;
        end else if (BLOCK) begin
          next_blocked[i] = 1'b1;
          next_start[i]   = 1'b0;
          next_alarm[i]   = 1'b0;
          next_tmr[i]     = '0;
        end else begin
          next_blocked[i] = 1'b0;
          next_start[i]   = 1'b1;
          next_tmr[i]     = START[i] && tmr[i] < dly[i] ? tmr[i] + DW'(1) : tmr[i];
          next_alarm[i]   = next_tmr[i] >= dly[i];
        end
      end
      next_on  = {|next_blocked & ~|BLOCKED, next_alarm & ~ALARM, next_start & ~START};
      next_off = {~|next_blocked & |BLOCKED, ~next_alarm & ALARM, ~next_start & START};
    end
    next_cond = |next_blocked ? 2'(distortion_pkg::COND_BLOCKED) :
                |next_alarm   ? 2'(distortion_pkg::COND_ALARM)   :
                |next_start   ? 2'(distortion_pkg::COND_START)   :
                                2'(distortion_pkg::COND_NORMAL);
    // write channel, address and data taken in either order
    next_aw_have = aw_have || (AWVALID && AWREADY);
    next_aw_addr = (AWVALID && AWREADY) ? AWADDR : aw_addr;
    next_w_have  = w_have || (WVALID && WREADY);
    next_w_data  = (WVALID && WREADY) ? WDATA : w_data;
    next_w_strb  = (WVALID && WREADY) ? WSTRB : w_strb;
    next_bvalid  = BVALID && !BREADY;
    next_bresp   = BRESP;
    if (wr) begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = distortion_pkg::RESP_OKAY;
      if (aw_addr == distortion_pkg::OFS_CTRL) begin
        wv          = merge({28'h0, enable, method}, w_data, w_strb);
        next_method = wv[distortion_pkg::CTRL_METHOD];
        next_enable = wv[distortion_pkg::CTRL_EN_LSB +: 3];
      end else if (aw_addr >= distortion_pkg::OFS_THR_PH && aw_addr <= distortion_pkg::OFS_THR_R2) begin
        wv = merge({18'h0, thr[aw_addr[3:2] - 2'h1]}, w_data, w_strb);
        next_thr[aw_addr[3:2] - 2'h1] = wv[31:14] != 18'h0 || wv[13:0] > distortion_pkg::THR_MAX ?
                                        distortion_pkg::THR_MAX : wv[13:0];
      end else if (aw_addr >= distortion_pkg::OFS_DLY_PH && aw_addr <= distortion_pkg::OFS_DLY_R2) begin
        wv = merge({13'h0, dly[aw_addr[3:2]]}, w_data, w_strb);
        next_dly[aw_addr[3:2]] = wv[31:DW] != '0 || wv[DW-1:0] > distortion_pkg::DLY_MAX ?
                                 distortion_pkg::DLY_MAX : wv[DW-1:0];
      end else if (aw_addr >= distortion_pkg::OFS_CNT_ST && aw_addr <= distortion_pkg::OFS_CNT_BL) begin
        next_cnt[aw_addr[3:2]] = '0;
      end else if (aw_addr != distortion_pkg::OFS_STATUS) begin
        next_bresp = distortion_pkg::RESP_SLVERR;
      end
    end
    // counters: an occurrence in the clearing cycle still counts
    next_cnt[0] = next_cnt[0] + CNT_W'(ones(tick ? next_start & ~START : 3'h0));
    next_cnt[1] = next_cnt[1] + CNT_W'(ones(tick ? next_alarm & ~ALARM : 3'h0));
    next_cnt[2] = next_cnt[2] + CNT_W'(tick && |next_blocked && !(|BLOCKED));
    // read channel
    next_rvalid = RVALID && !RREADY;
    next_rdata  = RDATA;
    next_rresp  = RRESP;
    if (ARVALID && ARREADY) begin
      next_rvalid = 1'b1;
      next_rresp  = distortion_pkg::RESP_OKAY;
      if (ARADDR == distortion_pkg::OFS_CTRL) begin
        next_rdata = {28'h0, enable, method};
      end else if (ARADDR >= distortion_pkg::OFS_THR_PH && ARADDR <= distortion_pkg::OFS_THR_R2) begin
        next_rdata = {18'h0, thr[ARADDR[3:2] - 2'h1]};
      end else if (ARADDR >= distortion_pkg::OFS_DLY_PH && ARADDR <= distortion_pkg::OFS_DLY_R2) begin
        next_rdata = {13'h0, dly[ARADDR[3:2]]};
      end else if (ARADDR == distortion_pkg::OFS_STATUS) begin
        next_rdata = {21'h0, BLOCKED, ALARM, START, MONITOR_CONDITION};
      end else if (ARADDR >= distortion_pkg::OFS_CNT_ST && ARADDR <= distortion_pkg::OFS_CNT_BL) begin
        next_rdata = 32'(cnt[ARADDR[3:2]]);
      end else begin
        next_rdata = 32'h0;
        next_rresp = distortion_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cyc               <= 32'h0;
      tick              <= 1'b0;
      method            <= 1'b0;
      enable            <= distortion_pkg::CTRL_RESET[3:1];
      thr               <= '{default: distortion_pkg::THR_RESET};
      dly               <= '{default: distortion_pkg::DLY_RESET};
      tmr               <= '{default: '0};
      cnt               <= '{default: '0};
      START             <= 3'h0;
      ALARM             <= 3'h0;
      BLOCKED           <= 3'h0;
      MONITOR_CONDITION <= 2'h0;
      EVENT_ON          <= 7'h00;
      EVENT_OFF         <= 7'h00;
      aw_have           <= 1'b0;
      w_have            <= 1'b0;
      aw_addr           <= 8'h00;
      w_data            <= 32'h0;
      w_strb            <= 4'h0;
      AWREADY           <= 1'b0;
      WREADY            <= 1'b0;
      BVALID            <= 1'b0;
      BRESP             <= 2'h0;
      ARREADY           <= 1'b0;
      RVALID            <= 1'b0;
      RDATA             <= 32'h0;
      RRESP             <= 2'h0;
    end else begin
      cyc               <= next_cyc;
      tick              <= next_tick;
      method            <= next_method;
      enable            <= next_enable;
      thr               <= next_thr;
      dly               <= next_dly;
      tmr               <= next_tmr;
      cnt               <= next_cnt;
      START             <= next_start;
      ALARM             <= next_alarm;
      BLOCKED           <= next_blocked;
      MONITOR_CONDITION <= next_cond;
      EVENT_ON          <= next_on;
      EVENT_OFF         <= next_off;
      aw_have           <= next_aw_have;
      w_have            <= next_w_have;
      aw_addr           <= next_aw_addr;
      w_data            <= next_w_data;
      w_strb            <= next_w_strb;
      AWREADY           <= !next_aw_have;
      WREADY            <= !next_w_have;
      BVALID            <= next_bvalid;
      BRESP             <= next_bresp;
      ARREADY           <= !next_rvalid;
      RVALID            <= next_rvalid;
      RDATA             <= next_rdata;
      RRESP             <= next_rresp;
    end
  end

  a_alarm_needs_start: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    (ALARM & ~START) == 3'h0) else $error("alarm without start");
  a_start_block_excl: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    (START & BLOCKED) == 3'h0) else $error("start and blocked together");
  a_block_drops_start: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    tick && BLOCK |=> START == 3'h0 && BLOCKED == $past(pick)) else $error("blocking kept start");
  a_start_on_pick: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    tick && !BLOCK && pick[1] |=> START[1] && !BLOCKED[1]) else $error("start missing");
  a_disabled_quiet: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    tick |=> ((START | ALARM | BLOCKED) & ~$past(enable)) == 3'h0) else $error("disabled active");
  a_cond_blocked: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    |BLOCKED |-> MONITOR_CONDITION == 2'h3) else $error("condition not blocked");
  a_alarm_on_tick: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    $rose(ALARM[0]) |-> $past(tick) && $past(tmr[0]) + 1 >= dly[0] || dly[0] == '0)
    else $error("alarm before delay");
  a_start_event: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    $rose(START[0]) |-> EVENT_ON[0] ##1 !EVENT_ON[0]) else $error("start event missing");
  a_tick_spacing: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    tick |=> !tick [*1]) else $error("program cycle too short");

  c_start: cover property (@(posedge SYS_CLK) disable iff (!rst_n) $rose(START[0]));
  c_alarm: cover property (@(posedge SYS_CLK) disable iff (!rst_n) $rose(ALARM[0]));
  c_blocked: cover property (@(posedge SYS_CLK) disable iff (!rst_n) START[1] ##1 BLOCKED[1]);
  c_write: cover property (@(posedge SYS_CLK) disable iff (!rst_n) BVALID && BREADY);
endmodule // distortion_monitor

// ---- bench/spectrum_source.sv ----
// spectrum front end and blocking source model
module spectrum_source (
  // clock
  input  wire logic clk,
  // spectrum and blocking
  output logic        valid,
  output logic [2:0]  channel,
  output logic [4:0]  order,
  output logic [15:0] mag,
  output logic        block
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {valid, channel, order, mag, block} = '0;
  end
  task automatic send(input logic [2:0] ch, input logic [15:0] f, input logic [15:0] h);
    for (int k = 0; k < 32; k++) begin
      @(posedge clk);
      valid   <= 1'b1;
      channel <= ch;
      order   <= 5'(k);
      mag     <= (k == 1) ? f : (k == 2) ? h : 16'h0000;
    end
    @(posedge clk);
    valid <= 1'b0;
    mag   <= ~mag;
  endtask
  // changed well over a program cycle before any delay runs out
  task automatic set_block(input logic b);
    @(posedge clk);
    block <= b;
  endtask
endmodule // spectrum_source

// ---- bench/harmonic_distortion_monitor_bench.sv ----
// self-checking bench for the harmonic distortion monitor
module harmonic_distortion_monitor_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, nrst, sv, blk, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [2:0]  sch, start, alarm, blocked;
  logic [4:0]  sord;
  logic [15:0] smag;
  logic [1:0]  cond, bresp, rresp;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [6:0]  ev_on, ev_off;
  logic [3:0]  wstrb;
  int          errors, n_tests, cyc;
  int          n_on, n_off;

  spectrum_source i_spectrum_source (.clk(clk), .valid(sv), .channel(sch), .order(sord),
    .mag(smag), .block(blk));
  distortion_monitor #(.CYCLE_CLKS(20)) i_distortion_monitor (.SYS_CLK(clk), .NRST(nrst),
    .SPEC_VALID(sv), .SPEC_CHANNEL(sch), .SPEC_ORDER(sord), .SPEC_MAGNITUDE(smag),
    .BLOCK(blk), .START(start), .ALARM(alarm), .BLOCKED(blocked), .MONITOR_CONDITION(cond),
    .EVENT_ON(ev_on), .EVENT_OFF(ev_off), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] rs(input bit bad);
    return 32'(bad ? distortion_pkg::RESP_SLVERR : distortion_pkg::RESP_OKAY);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit bad);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), rs(bad));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input bit bad);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk(32'(rresp), rs(bad));
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard, well above the fewer than one thousand cycles the tests need
  always @(posedge clk) begin
    cyc++;
    n_on  += $countones(ev_on);
    n_off += $countones(ev_off);
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    wt(16);
    nrst <= 1'b1;
    wt(4);
    rd(distortion_pkg::OFS_CTRL, 32'h0000_000E, 0);
    rd(distortion_pkg::OFS_THR_PH, 32'h0000_03E8, 0);
    rd(distortion_pkg::OFS_DLY_R2, 32'h0000_07D0, 0);
    rd(8'h40, 32'h0000_0000, 1);
    wr(8'h40, 32'h0000_0001, 1);
    wr(distortion_pkg::OFS_THR_R2, 32'h0000_4E20, 0);
    rd(distortion_pkg::OFS_THR_R2, 32'h0000_2710, 0);
    wr(distortion_pkg::OFS_THR_R2, 32'h0000_03E8, 0);
    note("registers");
    wr(distortion_pkg::OFS_CTRL, 32'h0000_000F, 0);
    wr(distortion_pkg::OFS_DLY_PH, 32'h0000_0003, 0);
    i_spectrum_source.send(3'h0, 16'h03E8, 16'h0190);
    wt(25);
    chk(32'(start), 32'h1);
    chk(32'(alarm), 32'h0);
    wt(65);
    chk(32'(alarm), 32'h1);
    rd(distortion_pkg::OFS_STATUS, 32'h0000_0026, 0);
    i_spectrum_source.send(3'h0, 16'h03E8, 16'h0139);
    wt(45);
    chk(32'(start), 32'h1);
    i_spectrum_source.send(3'h0, 16'h03E8, 16'h012C);
    wt(45);
    chk(32'(start | alarm), 32'h0);
    note("phase");
    i_spectrum_source.send(3'h3, 16'h0064, 16'h0014);
    wt(45);
    chk(32'(start), 32'h0);
    wr(distortion_pkg::OFS_CTRL, 32'h0000_000E, 0);
    i_spectrum_source.send(3'h3, 16'h0064, 16'h0014);
    wt(45);
    chk(32'(start), 32'h2);
    i_spectrum_source.send(3'h3, 16'h03E8, 16'h0062);
    wt(45);
    chk(32'(start), 32'h2);
    note("method");
    i_spectrum_source.set_block(1'b1);
    wt(45);
    chk(32'({start, blocked}), 32'h02);
    i_spectrum_source.send(3'h4, 16'h0064, 16'h0014);
    wt(45);
    chk(32'({start, blocked}), 32'h06);
    chk(32'(cond), 32'(distortion_pkg::COND_BLOCKED));
    rd(distortion_pkg::OFS_STATUS, 32'h0000_0603, 0);
    note("blocking");
    wr(distortion_pkg::OFS_CTRL, 32'h0000_000C, 0);
    i_spectrum_source.set_block(1'b0);
    i_spectrum_source.send(3'h1, 16'h0064, 16'h0028);
    wt(45);
    chk(32'({start, blocked}), 32'h30);
    rd(distortion_pkg::OFS_CNT_ST, 32'h0000_0004, 0);
    rd(distortion_pkg::OFS_CNT_AL, 32'h0000_0001, 0);
    rd(distortion_pkg::OFS_CNT_BL, 32'h0000_0001, 0);
    wr(distortion_pkg::OFS_CNT_ST, 32'h0000_0000, 0);
    rd(distortion_pkg::OFS_CNT_ST, 32'h0000_0000, 0);
    chk(32'(n_on), 32'h6);
    chk(32'(n_off), 32'h4);
    note("enables and counters");
    stop_test();
  end
endmodule // harmonic_distortion_monitor_bench
